/* File: design/fault_tracker_defines.vh */
// Constants for the two-trip fault tracker: channel layout, thresholds,
// condition windows and reset values. Assumes every includer is Verilog-2005 or SystemVerilog.
`ifndef FAULT_TRACKER_DEFINES_VH
`define FAULT_TRACKER_DEFINES_VH

// Channel layout
`define N_FAULTS           4
`define CH_IDX_W           2
// Set bit = misfire or fuel-injection class channel
`define INJ_CLASS_MASK     4'h3

// Field widths
`define RPM_W              16
`define LOAD_W             8
`define TEMP_W             8
`define CNT_W              7
`define REL_W              2
`define DIST_W             16

// Drive-cycle thresholds
`define LAMP_RELEASE_TRIPS 2'h3
`define AGING_TRIPS        7'h28
`define SIMILAR_TRIPS      7'h50

// Similar-conditions window
`define RPM_WINDOW         16'h0177
`define LOAD_TOL_DIV       12'h00a
// Coolant is carried as degrees C plus 40; split point 70 C
`define COOLANT_OFFSET     8'h28
`define COOLANT_SPLIT      8'h6e

// Reset values and distance ceiling
`define CNT_RST            7'h00
`define REL_RST            2'h0
`define DIST_RST           16'h0000
`define DIST_MAX           16'hffff
`define RPM_RST            16'h0000
`define LOAD_RST           8'h00
`define TEMP_RST           8'h00

`endif

/* File: design/fault_trip_tracker.v */
// One malfunction's pending/confirmed bookkeeping and its aging counter.
// Assumes all inputs come from logic on clk; trip_end is a one-cycle pulse.
`include "fault_tracker_defines.vh"
`default_nettype none

module fault_trip_tracker (
  // Clock and reset
  input  wire             clk,
  input  wire             reset,
  // Trip events
  input  wire             trip_end,
  input  wire             detect,
  input  wire             test_ok,
  input  wire             full_monitor,
  input  wire             aging_ok,
  input  wire             similar_ok,
  input  wire             erase,
  input  wire             inj_class,
  // Record state
  output wire             pending,
  output wire             pending_visible,
  output wire             pend_snap_valid,
  output wire             confirmed,
  output wire             confirmed_visible,
  output wire             first_hit,
  output wire             confirm_hit,
  output wire             detected_trip,
  output wire [`CNT_W-1:0] trip_count
);

  reg              det_ff;
  reg              ok_ff;
  reg              pend_ff;
  reg              psnap_ff;
  reg              hide_ff;
  reg              conf_ff;
  reg [`CNT_W-1:0] cnt_ff;

  wire             det_now = det_ff | detect;
  wire             ok_now  = ok_ff | test_ok;
  wire [`CNT_W-1:0] limit  = inj_class ? `SIMILAR_TRIPS : `AGING_TRIPS;
  wire             qualify = inj_class ? similar_ok : aging_ok;

  assign pending           = pend_ff;
  assign pending_visible   = pend_ff & ~hide_ff;
  assign pend_snap_valid   = psnap_ff;
  assign confirmed         = conf_ff;
  assign confirmed_visible = conf_ff & (cnt_ff < limit);
  assign first_hit         = trip_end & det_now & ~pend_ff;
  assign confirm_hit       = trip_end & det_now & pend_ff;
  assign detected_trip     = det_now;
  assign trip_count        = cnt_ff;

  always @(posedge clk) begin
    if (reset || erase) begin
      det_ff   <= 1'b0;
      ok_ff    <= 1'b0;
      pend_ff  <= 1'b0;
      psnap_ff <= 1'b0;
      hide_ff  <= 1'b0;
      conf_ff  <= 1'b0;
      cnt_ff   <= `CNT_RST;
    end else if (trip_end) begin
      det_ff <= 1'b0;
      ok_ff  <= 1'b0;
      if (det_now) begin
        cnt_ff  <= `CNT_RST;
        hide_ff <= 1'b0;
        if (pend_ff) begin
          conf_ff  <= 1'b1;
          psnap_ff <= 1'b0;
        end else begin
          pend_ff  <= 1'b1;
          psnap_ff <= 1'b1;
        end
      end else begin
        if (conf_ff && qualify && cnt_ff < limit) begin
          cnt_ff <= cnt_ff + 7'h01;
        end
        if (inj_class && conf_ff && similar_ok) begin
          pend_ff <= 1'b0;
        end
        if (!inj_class && full_monitor) begin
          pend_ff  <= 1'b0;
          psnap_ff <= 1'b0;
        end
        if (inj_class && ok_now) begin
          pend_ff  <= 1'b0;
          psnap_ff <= 1'b0;
        end
        if (pend_ff && ok_now) begin
          hide_ff <= 1'b1;
        end
      end
    end else begin
      det_ff <= det_ff | detect;
      ok_ff  <= ok_ff | test_ok;
      if (inj_class && test_ok && !det_now) begin
        pend_ff  <= 1'b0;
        psnap_ff <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* File: design/two_trip_fault_tracker.v */
// Top of the two-trip fault tracker: per-fault trackers, snapshots,
// similar-conditions check, lamp release, erase and scan-tool read port.
// Assumes every input comes from diagnostic logic on clk, not from pins.
`include "fault_tracker_defines.vh"
`default_nettype none

module two_trip_fault_tracker (
  // Clock and reset
  input  wire                 clk,
  input  wire                 reset,
  // Trip events
  input  wire                 trip_end,
  input  wire                 full_monitor,
  input  wire                 aging_ok,
  input  wire [`N_FAULTS-1:0] fault_detect,
  input  wire [`N_FAULTS-1:0] test_ok,
  // Live operating conditions
  input  wire                 cond_valid,
  input  wire [`RPM_W-1:0]    engine_rpm,
  input  wire [`LOAD_W-1:0]   calc_load,
  input  wire [`TEMP_W-1:0]   coolant_temp,
  // Distance and erase
  input  wire                 dist_tick,
  input  wire                 erase_cmd,
  // Scan-tool read port
  input  wire [`CH_IDX_W-1:0] rd_sel,
  output reg                  rd_pending,
  output reg                  rd_confirmed,
  output reg                  rd_stored,
  output reg  [`CNT_W-1:0]    rd_trip_count,
  output reg  [`RPM_W-1:0]    rd_snap_rpm,
  output reg  [`LOAD_W-1:0]   rd_snap_load,
  output reg  [`TEMP_W-1:0]   rd_snap_temp,
  // Lamp and summary
  output reg                  fault_lamp,
  output reg  [`REL_W-1:0]    lamp_release_count,
  output reg                  readiness,
  output reg  [`DIST_W-1:0]   lamp_distance,
  output reg  [`N_FAULTS-1:0] pending_mask,
  output reg  [`N_FAULTS-1:0] confirmed_mask
);

  // Snapshot memories
  reg  [`RPM_W-1:0]  prpm_ff  [0:`N_FAULTS-1];
  reg  [`LOAD_W-1:0] pload_ff [0:`N_FAULTS-1];
  reg  [`TEMP_W-1:0] ptemp_ff [0:`N_FAULTS-1];
  reg  [`RPM_W-1:0]  crpm_ff  [0:`N_FAULTS-1];
  reg  [`LOAD_W-1:0] cload_ff [0:`N_FAULTS-1];
  reg  [`TEMP_W-1:0] ctemp_ff [0:`N_FAULTS-1];

  // Per-trip similar-conditions latch
  reg  [`N_FAULTS-1:0] sim_ff;
  reg  [`N_FAULTS-1:0] nxt_sim;

  // Lamp bookkeeping
  reg  [`REL_W-1:0]    nxt_release;
  reg                  nxt_lamp;

  // Tracker results
  wire [`N_FAULTS-1:0] pend;
  wire [`N_FAULTS-1:0] pend_vis;
  wire [`N_FAULTS-1:0] psnap_vld;
  wire [`N_FAULTS-1:0] conf;
  wire [`N_FAULTS-1:0] conf_vis;
  wire [`N_FAULTS-1:0] first_hit;
  wire [`N_FAULTS-1:0] confirm_hit;
  wire [`N_FAULTS-1:0] det_trip;
  wire [`N_FAULTS-1:0] sim_match;
  wire [`N_FAULTS-1:0] sim_now;
  wire [`N_FAULTS*`CNT_W-1:0] cnt_flat;

  wire [`N_FAULTS-1:0] inj_mask = `INJ_CLASS_MASK;
  wire                 any_det  = |det_trip;
  wire                 any_conf = |confirm_hit;
  wire                 live_cold = coolant_temp < `COOLANT_SPLIT;

  integer i;
  integer j;

  genvar g;
  generate
    for (g = 0; g < `N_FAULTS; g = g + 1) begin : ch
      wire [`RPM_W-1:0]  rpm_diff;
      wire [`LOAD_W-1:0] load_diff;
      wire [11:0]        load_scaled;
      wire               rpm_ok;
      wire               load_ok;
      wire               temp_ok;

      // Absolute differences against the confirmed snapshot
      assign rpm_diff    = (engine_rpm >= crpm_ff[g]) ? (engine_rpm - crpm_ff[g]) :
                                                        (crpm_ff[g] - engine_rpm);
      assign load_diff   = (calc_load >= cload_ff[g]) ? (calc_load - cload_ff[g]) :
                                                        (cload_ff[g] - calc_load);
      assign load_scaled = {4'h0, load_diff} * `LOAD_TOL_DIV;
      assign rpm_ok      = rpm_diff <= `RPM_WINDOW;
      assign load_ok     = load_scaled <= {4'h0, cload_ff[g]};
      assign temp_ok     = live_cold == (ctemp_ff[g] < `COOLANT_SPLIT);
      assign sim_match[g] = conf[g] & rpm_ok & load_ok & temp_ok;
      assign sim_now[g]   = sim_ff[g] | (cond_valid & sim_match[g]);

      fault_trip_tracker u_trk (
        .clk               (clk),
        .reset             (reset),
        .trip_end          (trip_end),
        .detect            (fault_detect[g]),
        .test_ok           (test_ok[g]),
        .full_monitor      (full_monitor),
        .aging_ok          (aging_ok),
        .similar_ok        (sim_now[g]),
        .erase             (erase_cmd),
        .inj_class         (inj_mask[g]),
        .pending           (pend[g]),
        .pending_visible   (pend_vis[g]),
        .pend_snap_valid   (psnap_vld[g]),
        .confirmed         (conf[g]),
        .confirmed_visible (conf_vis[g]),
        .first_hit         (first_hit[g]),
        .confirm_hit       (confirm_hit[g]),
        .detected_trip     (det_trip[g]),
        .trip_count        (cnt_flat[g*`CNT_W +: `CNT_W])
      );
    end
  endgenerate

  // Similar-conditions latch: any matching sample in the trip counts
  always @* begin
    nxt_sim = sim_ff;
    for (j = 0; j < `N_FAULTS; j = j + 1) begin
      if (trip_end) begin
        nxt_sim[j] = 1'b0;
      end else if (cond_valid && sim_match[j]) begin
        nxt_sim[j] = 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (reset || erase_cmd) begin
      sim_ff <= {`N_FAULTS{1'b0}};
    end else begin
      sim_ff <= nxt_sim;
    end
  end

  // Snapshot capture; hidden confirmed snapshots are kept
  always @(posedge clk) begin
    for (i = 0; i < `N_FAULTS; i = i + 1) begin
      if (reset || erase_cmd) begin
        prpm_ff[i]  <= `RPM_RST;
        pload_ff[i] <= `LOAD_RST;
        ptemp_ff[i] <= `TEMP_RST;
        crpm_ff[i]  <= `RPM_RST;
        cload_ff[i] <= `LOAD_RST;
        ctemp_ff[i] <= `TEMP_RST;
      end else begin
        if (first_hit[i]) begin
          prpm_ff[i]  <= engine_rpm;
          pload_ff[i] <= calc_load;
          ptemp_ff[i] <= coolant_temp;
        end
        if (confirm_hit[i]) begin
          crpm_ff[i]  <= engine_rpm;
          cload_ff[i] <= calc_load;
          ctemp_ff[i] <= coolant_temp;
        end
      end
    end
  end

  // Lamp-release counter and lamp
  always @* begin
    nxt_release = lamp_release_count;
    nxt_lamp    = fault_lamp;
    if (trip_end) begin
      if (any_det) begin
        nxt_release = `REL_RST;
      end else if (full_monitor && lamp_release_count < `LAMP_RELEASE_TRIPS) begin
        nxt_release = lamp_release_count + 2'h1;
      end
    end
    if (any_conf) begin
      nxt_lamp = 1'b1;
    end else if (nxt_release == `LAMP_RELEASE_TRIPS) begin
      nxt_lamp = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (reset || erase_cmd) begin
      lamp_release_count <= `REL_RST;
      fault_lamp         <= 1'b0;
    end else begin
      lamp_release_count <= nxt_release;
      fault_lamp         <= nxt_lamp;
    end
  end

  // Readiness and lamp-on distance
  always @(posedge clk) begin
    if (reset || erase_cmd) begin
      readiness     <= 1'b0;
      lamp_distance <= `DIST_RST;
    end else begin
      if (trip_end && full_monitor) begin
        readiness <= 1'b1;
      end
      if (dist_tick && fault_lamp && lamp_distance != `DIST_MAX) begin
        lamp_distance <= lamp_distance + 16'h0001;
      end
    end
  end

  // Scan-tool view, registered every cycle
  always @(posedge clk) begin
    if (reset) begin
      rd_pending     <= 1'b0;
      rd_confirmed   <= 1'b0;
      rd_stored      <= 1'b0;
      rd_trip_count  <= `CNT_RST;
      rd_snap_rpm    <= `RPM_RST;
      rd_snap_load   <= `LOAD_RST;
      rd_snap_temp   <= `TEMP_RST;
      pending_mask   <= {`N_FAULTS{1'b0}};
      confirmed_mask <= {`N_FAULTS{1'b0}};
    end else begin
      rd_pending     <= pend_vis[rd_sel];
      rd_confirmed   <= conf_vis[rd_sel];
      rd_stored      <= conf[rd_sel];
      rd_trip_count  <= cnt_flat[rd_sel*`CNT_W +: `CNT_W];
      pending_mask   <= pend_vis;
      confirmed_mask <= conf_vis;
      if (conf_vis[rd_sel]) begin
        rd_snap_rpm  <= crpm_ff[rd_sel];
        rd_snap_load <= cload_ff[rd_sel];
        rd_snap_temp <= ctemp_ff[rd_sel];
      end else if (psnap_vld[rd_sel]) begin
        rd_snap_rpm  <= prpm_ff[rd_sel];
        rd_snap_load <= pload_ff[rd_sel];
        rd_snap_temp <= ptemp_ff[rd_sel];
      end else begin
        rd_snap_rpm  <= `RPM_RST;
        rd_snap_load <= `LOAD_RST;
        rd_snap_temp <= `TEMP_RST;
      end
    end
  end

endmodule

`default_nettype wire

/* File: bench/two_trip_fault_tracker_properties.sv */
// Checker for the two-trip fault tracker top: lamp, masks, read port.
// Assumes one clock domain and the top's sync active-high reset.
`include "fault_tracker_defines.vh"
`default_nettype none
module fault_tracker_checker (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 reset,
  // Events
  input wire logic                 trip_end,
  input wire logic                 erase_cmd,
  input wire logic [`CH_IDX_W-1:0] rd_sel,
  // Observed state
  input wire logic                 rd_pending,
  input wire logic                 rd_confirmed,
  input wire logic                 rd_stored,
  input wire logic [`CNT_W-1:0]    rd_trip_count,
  input wire logic                 fault_lamp,
  input wire logic [`REL_W-1:0]    lamp_release_count,
  input wire logic [`DIST_W-1:0]   lamp_distance,
  input wire logic [`N_FAULTS-1:0] pending_mask,
  input wire logic [`N_FAULTS-1:0] confirmed_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_lamp_at_trip: assert property ($rose(fault_lamp) |-> $past(trip_end))
    else $error("lamp lit outside a trip end");
  a_lamp_has_confirm: assert property ($rose(fault_lamp) && !erase_cmd
    |=> confirmed_mask != 4'h0)
    else $error("lamp lit without a confirmed code");
  a_lamp_off_trip: assert property ($fell(fault_lamp)
    |-> $past(trip_end) || $past(erase_cmd))
    else $error("lamp went off outside a trip end");
  a_release_step: assert property ($changed(lamp_release_count)
    && lamp_release_count != 2'h0
    |-> lamp_release_count == $past(lamp_release_count) + 2'h1)
    else $error("release count skipped a step");
  a_pending_port: assert property (rd_pending == pending_mask[$past(rd_sel)])
    else $error("read port pending differs from mask");
  a_confirm_port: assert property (rd_confirmed == confirmed_mask[$past(rd_sel)])
    else $error("read port confirmed differs from mask");
  a_hidden_kept: assert property (rd_confirmed |-> rd_stored)
    else $error("visible code not stored");
  a_pending_trip: assert property ((pending_mask & ~$past(pending_mask)) != 4'h0
    |-> $past(trip_end, 2))
    else $error("pending code set outside a trip end");
  a_count_limit: assert property (rd_trip_count <= `SIMILAR_TRIPS)
    else $error("trip count above its ceiling");
  a_erase_codes: assert property (erase_cmd ##1 !trip_end
    |=> pending_mask == 4'h0 && confirmed_mask == 4'h0)
    else $error("codes survive erase");
  a_erase_lamp: assert property (erase_cmd
    |-> ##2 !fault_lamp && lamp_distance == 16'h0000)
    else $error("lamp or distance survive erase");

  c_lamp_on: cover property ($rose(fault_lamp));
  c_lamp_off: cover property ($fell(fault_lamp));
  c_aged_out: cover property (rd_stored && !rd_confirmed);
endmodule

bind two_trip_fault_tracker fault_tracker_checker u_fault_tracker_checker (
  .clk(clk), .reset(reset), .trip_end(trip_end), .erase_cmd(erase_cmd), .rd_sel(rd_sel),
  .rd_pending(rd_pending), .rd_confirmed(rd_confirmed), .rd_stored(rd_stored),
  .rd_trip_count(rd_trip_count), .fault_lamp(fault_lamp),
  .lamp_release_count(lamp_release_count), .lamp_distance(lamp_distance),
  .pending_mask(pending_mask), .confirmed_mask(confirmed_mask));
`default_nettype wire

/* File: bench/scan_tool_model.sv */
// Scan-tool model: selects a channel on the read port, keeps the last record.
// Assumes the read port answers one clock after the selection.
`default_nettype none
module scan_tool_model (
  // Clock and request
  input  wire logic       clk,
  input  wire logic [1:0] want_ch,
  // Read port
  output var  logic [1:0] rd_sel,
  input  wire logic       rd_pending,
  input  wire logic       rd_confirmed,
  input  wire logic       rd_stored,
  input  wire logic [6:0] rd_trip_count,
  // Captured record
  output var  logic [9:0] rec
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    rd_sel <= #1 want_ch;
    rec    <= {rd_pending, rd_confirmed, rd_stored, rd_trip_count};
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the two-trip fault tracker with a scan-tool model.
// Assumes read port and masks lag state by one clock, lamp does not.
`include "fault_tracker_defines.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [3:0] det, ok;
    logic       fm, ag, lamp;
    logic [1:0] rel;
    logic [3:0] pend, conf;
  } row_t;
  localparam logic [31:0] base_cond = {16'h0352, 8'h1e, 8'h78};
  logic       clk = 1'h0;
  logic       reset, trip_end, full_monitor, aging_ok, cond_valid, dist_tick, erase_cmd;
  logic       fault_lamp, readiness, rd_pending, rd_confirmed, rd_stored;
  logic [3:0] fault_detect, test_ok, pending_mask, confirmed_mask;
  logic [15:0] engine_rpm, lamp_distance, rd_snap_rpm;
  logic [7:0] calc_load, coolant_temp, rd_snap_load, rd_snap_temp;
  logic [1:0] rd_sel, want_ch, lamp_release_count;
  logic [6:0] rd_trip_count;
  logic [9:0] rec;
  int         err_count = 0;
  int         comparisons = 0;
  int         cycles = 0;
  row_t rows [9] = '{
    '{4'h4, 4'h0, 1'h0, 1'h0, 1'h0, 2'h0, 4'h4, 4'h0},
    '{4'h4, 4'h0, 1'h0, 1'h0, 1'h1, 2'h0, 4'h4, 4'h4},
    '{4'h0, 4'h0, 1'h1, 1'h0, 1'h1, 2'h1, 4'h0, 4'h4},
    '{4'h8, 4'h0, 1'h1, 1'h0, 1'h1, 2'h0, 4'h8, 4'h4},
    '{4'h0, 4'h8, 1'h0, 1'h0, 1'h1, 2'h0, 4'h0, 4'h4},
    '{4'h0, 4'h0, 1'h1, 1'h0, 1'h1, 2'h1, 4'h0, 4'h4},
    '{4'h0, 4'h0, 1'h1, 1'h0, 1'h1, 2'h2, 4'h0, 4'h4},
    '{4'h0, 4'h0, 1'h1, 1'h0, 1'h0, 2'h3, 4'h0, 4'h4},
    '{4'h0, 4'h0, 1'h1, 1'h0, 1'h0, 2'h3, 4'h0, 4'h4}};
  // Live conditions and trip count expected after each similar-check trip
  logic [38:0] sim_rows [6] = '{
    {16'h04c9, 8'h21, 8'h78, 7'h01}, {16'h04ca, 8'h1e, 8'h78, 7'h01},
    {16'h0352, 8'h22, 8'h78, 7'h01}, {16'h01db, 8'h1b, 8'h6e, 7'h02},
    {16'h0352, 8'h1e, 8'h6d, 7'h02}, {16'h01da, 8'h1e, 8'h78, 7'h02}};

  two_trip_fault_tracker u_two_trip_fault_tracker (.clk(clk), .reset(reset),
    .trip_end(trip_end), .full_monitor(full_monitor), .aging_ok(aging_ok),
    .fault_detect(fault_detect), .test_ok(test_ok), .cond_valid(cond_valid),
    .engine_rpm(engine_rpm), .calc_load(calc_load), .coolant_temp(coolant_temp),
    .dist_tick(dist_tick), .erase_cmd(erase_cmd), .rd_sel(rd_sel), .rd_pending(rd_pending),
    .rd_confirmed(rd_confirmed), .rd_stored(rd_stored), .rd_trip_count(rd_trip_count),
    .rd_snap_rpm(rd_snap_rpm), .rd_snap_load(rd_snap_load), .rd_snap_temp(rd_snap_temp),
    .fault_lamp(fault_lamp), .lamp_release_count(lamp_release_count), .readiness(readiness),
    .lamp_distance(lamp_distance), .pending_mask(pending_mask),
    .confirmed_mask(confirmed_mask));
  scan_tool_model u_scan_tool_model (.clk(clk), .want_ch(want_ch), .rd_sel(rd_sel),
    .rd_pending(rd_pending), .rd_confirmed(rd_confirmed), .rd_stored(rd_stored),
    .rd_trip_count(rd_trip_count), .rec(rec));

  always #5 clk = ~clk;

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wrap_up;
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic do_reset;
    reset = 1'h1;
    repeat (12) step;
    chk("fault_lamp", 16'h0, fault_lamp);
    chk("masks", 16'h0, {pending_mask, confirmed_mask});
    reset = 1'h0;
    {engine_rpm, calc_load, coolant_temp} = base_cond;
    step;
  endtask

  task automatic trip(input logic [3:0] det, ok, input logic fm, ag, cv);
    {fault_detect, test_ok, full_monitor, aging_ok, cond_valid, trip_end} =
      {det, ok, fm, ag, cv, 1'h1};
    step;
    {fault_detect, test_ok, cond_valid, trip_end} = 10'h0;
    repeat (2) step;
  endtask

  task automatic look(input logic [1:0] ch);
    want_ch = ch;
    repeat (4) step;
  endtask

  // Clean trips until one trip past the point where the counter reaches its ceiling
  task automatic aging(input logic [1:0] ch, input int first, lim, input logic ag, cv);
    for (int k = first; k <= lim + 1; k++) begin
      trip(4'h0, 4'h0, 1'h0, ag, cv);
      look(ch);
      chk("rd_trip_count", 16'(k < lim ? k : lim), rec[6:0]);
      chk("rd_confirmed", 16'(k < lim), rec[8]);
      chk("rd_stored", 16'h1, rec[7]);
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      wrap_up;
    end
  end

  initial begin
    {trip_end, full_monitor, aging_ok, cond_valid, dist_tick, erase_cmd} = 6'h0;
    {fault_detect, test_ok, want_ch} = 10'h0;
    do_reset;
    for (int i = 0; i < 9; i++) begin
      trip(rows[i].det, rows[i].ok, rows[i].fm, rows[i].ag, 1'h0);
      chk("fault_lamp", rows[i].lamp, fault_lamp);
      chk("lamp_release_count", rows[i].rel, lamp_release_count);
      chk("pending_mask", rows[i].pend, pending_mask);
      chk("confirmed_mask", rows[i].conf, confirmed_mask);
    end
    chk("readiness", 16'h1, readiness);
    look(2'h2);
    chk("snapshot", base_cond[31:16], rd_snap_rpm);
    chk("snapshot load", 16'(base_cond[15:8]), rd_snap_load);
    chk("snapshot temp", 16'(base_cond[7:0]), rd_snap_temp);
    // General class aging, distance and erase
    do_reset;
    trip(4'h4, 4'h0, 1'h0, 1'h0, 1'h0);
    trip(4'h4, 4'h0, 1'h0, 1'h0, 1'h0);
    repeat (3) begin
      dist_tick = 1'h1;
      step;
      dist_tick = 1'h0;
      step;
    end
    step;
    chk("lamp_distance", 16'h3, lamp_distance);
    aging(2'h2, 1, 40, 1'h1, 1'h0);
    chk("pending snapshot dropped", 16'h0, rd_snap_rpm);
    trip(4'h4, 4'h0, 1'h0, 1'h0, 1'h0);
    look(2'h2);
    chk("rd_trip_count", 16'h0, rec[6:0]);
    erase_cmd = 1'h1;
    step;
    erase_cmd = 1'h0;
    look(2'h2);
    chk("erase lamp", 16'h0, fault_lamp);
    chk("erase distance", 16'h0, lamp_distance);
    chk("erase masks", 16'h0, {pending_mask, confirmed_mask});
    chk("erase readiness", 16'h0, readiness);
    chk("erase record", 16'h0, rec[9:7]);
    // Injection class: OK clear, similar conditions, aging to 80
    do_reset;
    trip(4'h2, 4'h0, 1'h0, 1'h0, 1'h0);
    look(2'h1);
    chk("pending snapshot", base_cond[31:16], rd_snap_rpm);
    test_ok = 4'h2;
    step;
    test_ok = 4'h0;
    look(2'h1);
    chk("pending after ok", 16'h0, pending_mask);
    chk("snapshot after ok", 16'h0, rd_snap_rpm);
    trip(4'h2, 4'h0, 1'h0, 1'h0, 1'h0);
    trip(4'h2, 4'h0, 1'h0, 1'h0, 1'h0);
    for (int i = 0; i < 6; i++) begin
      {engine_rpm, calc_load, coolant_temp} = sim_rows[i][38:7];
      trip(4'h0, 4'h0, 1'h0, 1'h0, 1'h1);
      look(2'h1);
      chk("similar count", 16'(sim_rows[i][6:0]), rec[6:0]);
      chk("rd_pending", 16'h0, rec[9]);
    end
    // Match seen mid-trip still counts at trip end
    {engine_rpm, calc_load, coolant_temp} = base_cond;
    cond_valid = 1'h1;
    step;
    cond_valid = 1'h0;
    {engine_rpm, calc_load, coolant_temp} = sim_rows[1][38:7];
    trip(4'h0, 4'h0, 1'h0, 1'h0, 1'h1);
    look(2'h1);
    chk("latched similar", 16'h3, rec[6:0]);
    {engine_rpm, calc_load, coolant_temp} = base_cond;
    aging(2'h1, 4, 80, 1'h0, 1'h1);
    trip(4'h2, 4'h0, 1'h0, 1'h0, 1'h1);
    look(2'h1);
    chk("similar count", 16'h0, rec[6:0]);
    wrap_up;
  end
endmodule
`default_nettype wire
